// ==== rtl/lvr_pkg.sv ====
// Package: constants and carriers for the low-voltage and runaway reset supervisor
package lvr_pkg;
   localparam int RUNAWAY_WIDTH = 20;
   localparam int RESET_HOLD_CYCLES = 5;
   localparam logic [2:0] RESET_HOLD_LAST = 3'h4;
   localparam logic [RUNAWAY_WIDTH-1:0] RUNAWAY_RESET_VALUE = 20'h00000;
   localparam logic FLAG_RESET_VALUE = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_WAIT = 2'b11
   } rst_state_e;

   // Processor operating mode indications
   typedef struct packed {
      logic stop_mode;
      logic sleep_entry;
      logic timebase_entry;
      logic watch_entry;
      logic cpu_halted;
   } cpu_mode_s;

   // Software access to the supervisor control register
   typedef struct packed {
      logic wr;
      logic clear_bit;
      logic flag_wr;
      logic flag_wdata;
   } sup_ctrl_s;
endpackage : lvr_pkg

// ==== rtl/runaway_counter.sv ====
// Runaway detection counter stepped by oscillation clock ticks
`timescale 1ns/1ps
module runaway_counter #(
   parameter int WIDTH = lvr_pkg::RUNAWAY_WIDTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Control
   input wire logic osc_tick_i,
   input wire logic count_en_i,
   input wire logic clear_i,
   // Status
   output logic expire_o
);
   logic [WIDTH-1:0] count;
   logic expire;
   wire logic at_top = &count;
   wire logic step = osc_tick_i & count_en_i;

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || clear_i) begin
         count <= WIDTH'(lvr_pkg::RUNAWAY_RESET_VALUE); // [R10]
      end else if (step) begin
         count <= count + 1'b1; // [R5] [R11]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || clear_i) begin
         expire <= 1'b0;
      end else begin
         expire <= step & at_top; // [R8]
      end
   end

   assign expire_o = expire;
endmodule : runaway_counter

// ==== rtl/lvr_supervisor.sv ====
// Low-voltage and runaway reset supervisor top level
//
// Summary of operation
// R1 - Low-voltage indication sets the low-voltage flag and asserts internal reset.
// R2 - Monitor stays active in stop mode; its reset also ends stop mode.
// R3 - Low-voltage reset waits until a RAM write in progress finishes.
// R4 - Further low-voltage requests are masked while internal reset is active.
// R5 - Runaway detector is a 20-bit counter stepped by the oscillation clock.
// R6 - Uncleared counter causes reset; software must clear it periodically.
// R7 - Power-on-only registers are not touched by internal resets.
// R8 - Runaway interval is 2^20 oscillation clock periods.
// R9 - Runaway internal reset lasts exactly 5 machine cycles.
// R10 - Counter cleared by clear bit zero, internal reset, osc stop, sleep, timebase, watch.
// R11 - Counter does not advance while CPU operation is stopped.
// R12 - Both requests merge into one internal reset output.
`timescale 1ns/1ps
module lvr_supervisor #(
   parameter int COUNT_WIDTH = lvr_pkg::RUNAWAY_WIDTH
) (
   // Clock and power-on reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Analog monitor and memory
   input wire logic low_voltage_i,
   input wire logic ram_write_busy_i,
   // Oscillator
   input wire logic osc_tick_i,
   input wire logic osc_stopped_i,
   // Processor state and software access
   input wire lvr_pkg::cpu_mode_s cpu_mode_i,
   input wire lvr_pkg::sup_ctrl_s sup_ctrl_i,
   // Reset network
   output logic internal_reset_o,
   output logic stop_release_o,
   output logic low_voltage_flag_o,
   output logic runaway_flag_o
);
   lvr_pkg::rst_state_e state;
   lvr_pkg::rst_state_e next_state;
   logic [2:0] hold_cnt;
   logic low_voltage_flag;
   logic runaway_flag;
   logic internal_reset;
   logic stop_release;
   logic runaway_expire;

   // Request decode
   wire logic in_reset = (state == lvr_pkg::ST_HOLD);
   wire logic lv_request = low_voltage_i & ~in_reset; // [R4]
   wire logic lv_fire = lv_request & ~ram_write_busy_i; // [R3]
   wire logic any_fire = lv_fire | runaway_expire; // [R12]
   wire logic hold_done = in_reset & (hold_cnt == lvr_pkg::RESET_HOLD_LAST);
   wire logic sw_clear = sup_ctrl_i.wr & ~sup_ctrl_i.clear_bit;
   wire logic mode_clear = cpu_mode_i.sleep_entry | cpu_mode_i.timebase_entry | cpu_mode_i.watch_entry;
   wire logic cnt_clear = sw_clear | internal_reset | osc_stopped_i | mode_clear; // [R10] [R6]
   wire logic cnt_enable = ~cpu_mode_i.cpu_halted & ~cpu_mode_i.stop_mode; // [R11]
   wire logic next_reset = (next_state == lvr_pkg::ST_HOLD);

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         lvr_pkg::ST_IDLE: begin
            if (runaway_expire || lv_fire) begin
               next_state = lvr_pkg::ST_HOLD;
            end else if (lv_request) begin
               next_state = lvr_pkg::ST_WAIT; // [R3]
            end
         end
         lvr_pkg::ST_WAIT: begin
            if (any_fire || !ram_write_busy_i) begin
               next_state = lvr_pkg::ST_HOLD;
            end
         end
         lvr_pkg::ST_HOLD: begin
            if (hold_done) begin
               next_state = lvr_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = lvr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state <= lvr_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Reset width counter
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || !in_reset) begin
         hold_cnt <= 3'h0;
      end else begin
         hold_cnt <= hold_cnt + 3'h1; // [R9]
      end
   end

   // Combined reset output and stop release
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         internal_reset <= 1'b0;
         stop_release <= 1'b0;
      end else begin
         internal_reset <= next_reset; // [R12] [R1]
         stop_release <= next_reset & cpu_mode_i.stop_mode; // [R2]
      end
   end

   // Flags kept across internal resets, cleared at power-on or by a software flag write
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         low_voltage_flag <= lvr_pkg::FLAG_RESET_VALUE; // [R7]
         runaway_flag <= lvr_pkg::FLAG_RESET_VALUE;
      end else begin
         if (low_voltage_i) begin
            low_voltage_flag <= 1'b1; // [R1]
         end else if (sup_ctrl_i.flag_wr) begin
            low_voltage_flag <= sup_ctrl_i.flag_wdata;
         end
         if (runaway_expire) begin
            runaway_flag <= 1'b1;
         end else if (sup_ctrl_i.flag_wr && !sup_ctrl_i.flag_wdata) begin
            runaway_flag <= 1'b0;
         end
      end
   end

   runaway_counter #(
      .WIDTH(COUNT_WIDTH)
   ) u_runaway (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .osc_tick_i(osc_tick_i),
      .count_en_i(cnt_enable),
      .clear_i(cnt_clear),
      .expire_o(runaway_expire)
   );

   assign internal_reset_o = internal_reset;
   assign stop_release_o = stop_release;
   assign low_voltage_flag_o = low_voltage_flag;
   assign runaway_flag_o = runaway_flag;
endmodule : lvr_supervisor

// ==== tb/lvr_supervisor_properties.sv ====
// Checker for the supervisor ports
`timescale 1ns/1ps
module lvr_checker (
   // Inputs
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic low_voltage_i,
   input wire logic ram_write_busy_i,
   input wire lvr_pkg::cpu_mode_s cpu_mode_i,
   input wire lvr_pkg::sup_ctrl_s sup_ctrl_i,
   // Outputs
   input wire logic internal_reset_o,
   input wire logic stop_release_o,
   input wire logic low_voltage_flag_o,
   input wire logic runaway_flag_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   property p_rise; low_voltage_i && !internal_reset_o && !ram_write_busy_i |=> internal_reset_o; endproperty
   a_rise: assert property (p_rise) else $error("no reset");
   property p_flag; low_voltage_i |=> low_voltage_flag_o; endproperty
   a_flag: assert property (p_flag) else $error("flag");
   property p_hold; $rose(internal_reset_o) |-> internal_reset_o[*5] ##1 !internal_reset_o; endproperty
   a_hold: assert property (p_hold) else $error("width");
   property p_retrig; $fell(internal_reset_o) && low_voltage_i && !ram_write_busy_i |=> internal_reset_o; endproperty
   a_retrig: assert property (p_retrig) else $error("retrigger");
   property p_kept; low_voltage_flag_o && !sup_ctrl_i.flag_wr |=> low_voltage_flag_o; endproperty
   a_kept: assert property (p_kept) else $error("flag lost");
   property p_run; $rose(runaway_flag_o) |-> ##[0:1] internal_reset_o; endproperty
   a_run: assert property (p_run) else $error("runaway");
   property p_stop; $rose(internal_reset_o) && $past(cpu_mode_i.stop_mode) |-> stop_release_o; endproperty
   a_stop: assert property (p_stop) else $error("stop");
   property p_halt; cpu_mode_i.cpu_halted[*3] ##0 !(low_voltage_i || ram_write_busy_i
      || $past(ram_write_busy_i) || internal_reset_o) |=> !internal_reset_o; endproperty
   a_halt: assert property (p_halt) else $error("halt");
endmodule : lvr_checker
bind lvr_supervisor lvr_checker u_chk (.*);

// ==== tb/osc_model.sv ====
// Oscillator ticks and software clear
`timescale 1ns/1ps
module osc_model (
   // Clock and control
   input wire logic clk_sys_i,
   input wire logic run_i,
   input wire logic clr_en_i,
   // Outputs
   output logic tick_o,
   output logic clr_o
);
   logic [4:0] cnt = 5'h00;
   always_ff @(posedge clk_sys_i) cnt <= run_i ? cnt + 5'h01 : 5'h00;
   assign tick_o = run_i & cnt[0];
   assign clr_o = clr_en_i & (cnt[3:0] == 4'h9);
endmodule : osc_model

// ==== tb/lvr_supervisor_bench.sv ====
// Bench for the supervisor
`timescale 1ns/1ps
module lvr_supervisor_bench;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic lv = 1'b0;
   logic busy = 1'b0;
   logic run = 1'b0;
   logic clr_en = 1'b0;
   logic ostop = 1'b0;
   logic fwr = 1'b0;
   logic tick, clr, rst, rel, flag, rflag;
   lvr_pkg::cpu_mode_s mode = '0;
   int n_mismatch = 0;
   int checks = 0;
   initial forever #10 clk_sys_i = ~clk_sys_i;
   osc_model u_osc (.clk_sys_i, .run_i(run), .clr_en_i(clr_en), .tick_o(tick), .clr_o(clr));
   lvr_supervisor #(.COUNT_WIDTH(4)) dut (.clk_sys_i, .resetn_i, .low_voltage_i(lv), .ram_write_busy_i(busy),
      .osc_tick_i(tick), .osc_stopped_i(ostop), .cpu_mode_i(mode), .sup_ctrl_i({clr, 1'b0, fwr, 1'b0}),
      .internal_reset_o(rst), .stop_release_o(rel), .low_voltage_flag_o(flag), .runaway_flag_o(rflag));
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : step
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic print_verdict;
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #10000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      step(5);
      resetn_i <= 1'b1;
      #1 chk(rst === 1'b0 && flag === 1'b0 && rflag === 1'b0, "reset values");
      step(1);
      lv <= 1'b1;
      step(1);
      lv <= 1'b0;
      #1 chk(rst === 1'b1 && flag === 1'b1, "low voltage reset");
      step(3);
      lv <= 1'b1;
      step(1);
      lv <= 1'b0;
      step(1);
      #1 chk(rst === 1'b0, "reset width");
      step(1);
      #1 chk(rst === 1'b0, "request not masked");
      busy <= 1'b1;
      lv <= 1'b1;
      step(3);
      #1 chk(rst === 1'b0, "reset during ram write");
      step(1);
      busy <= 1'b0;
      lv <= 1'b0;
      step(2);
      #1 chk(rst === 1'b1, "no reset after write");
      step(6);
      mode.stop_mode <= 1'b1;
      lv <= 1'b1;
      step(1);
      lv <= 1'b0;
      #1 chk(rst === 1'b1 && rel === 1'b1, "stop not released");
      step(6);
      mode <= '0;
      run <= 1'b1;
      step(31);
      #1 chk(rst === 1'b0, "runaway early");
      step(4);
      run <= 1'b0;
      #1 chk(rst === 1'b1 && rflag === 1'b1, "runaway missing");
      chk(flag === 1'b1, "flag cleared by reset");
      step(8);
      run <= 1'b1;
      clr_en <= 1'b1;
      repeat (60) begin
         step(1);
         #1 chk(rst === 1'b0, "reset despite clear");
      end
      step(1);
      clr_en <= 1'b0;
      mode.cpu_halted <= 1'b1;
      repeat (60) begin
         step(1);
         #1 chk(rst === 1'b0, "count while halted");
      end
      step(1);
      mode <= 5'h08;
      repeat (60) begin
         step(1);
         #1 chk(rst === 1'b0, "reset despite sleep entry");
      end
      step(1);
      mode <= '0;
      ostop <= 1'b1;
      repeat (60) begin
         step(1);
         #1 chk(rst === 1'b0, "reset despite osc stop");
      end
      step(1);
      ostop <= 1'b0;
      run <= 1'b0;
      fwr <= 1'b1;
      step(1);
      fwr <= 1'b0;
      #1 chk(flag === 1'b0 && rflag === 1'b0, "flag write ignored");
      print_verdict();
   end
endmodule : lvr_supervisor_bench
